// >>> dbgca_consts.svh
// Constants of debug comparator A: offsets, bit positions,
// reset values and widths. Included by package and block.
`ifndef DBGCA_CONSTS_SVH
`define DBGCA_CONSTS_SVH

// Widths
`define DBGCA_RAW        16
`define DBGCA_AW         24
`define DBGCA_DW         32

// Register byte offsets
`define DBGCA_CTL_OFS    16'h0110
`define DBGCA_STAT_OFS   16'h0111
`define DBGCA_ADDR_OFS   16'h0115
`define DBGCA_DATA_OFS   16'h0118
`define DBGCA_MASK_OFS   16'h011c

// Control bit positions
`define DBGCA_INV_BIT    6
`define DBGCA_PC_BIT     5
`define DBGCA_DIR_BIT    3
`define DBGCA_DIRE_BIT   2
`define DBGCA_ON_BIT     0

// Writable control bits
`define DBGCA_CTL_WMASK  8'h6d

// Status bit positions
`define DBGCA_ST_PROF    0
`define DBGCA_ST_BLOCK   1
`define DBGCA_ST_MATCH   2

// Reset values
`define DBGCA_CTL_RST    8'h00
`define DBGCA_ADDR_RST   24'h000000
`define DBGCA_DATA_RST   32'h00000000
`define DBGCA_MASK_RST   32'h00000000

`endif

// >>> dbgca_pkg.sv
// Types of debug comparator A.
// Assumes dbgca_consts.svh is on the include path.
`include "dbgca_consts.svh"

package dbgca_pkg;

  typedef struct packed {
    logic [7:0]            ctl;
    logic [`DBGCA_AW-1:0]  addr;
    logic [`DBGCA_DW-1:0]  data;
    logic [`DBGCA_DW-1:0]  mask;
    logic                  prof;
    logic                  match;
    logic [7:0]            rdata;
  } dbgca_state_t;

endpackage : dbgca_pkg

// >>> dbgca_match.sv
// Debug comparator A: registers and match logic.
// Assumes core buses and session inputs share the clock.
//
// What this block does
// (RULE1) Writes ignored while armed or profiling
// (RULE2) Inversion bit selects equal or differ
// (RULE3) Bit 5 picks data or PC address
// (RULE4) Bit 3 selects write or read
// (RULE5) Bit 2 enables direction qualification
// (RULE6) No match unless bit 0 set
// (RULE7) Qualified direction must equal direction bit
// (RULE8) PC matches ignore data and direction
// (RULE9) 24-bit address compared bit for bit
// (RULE10) 32-bit data compared bit for bit
// (RULE11) Only mask-one bits take part
// (RULE12) Data bytes, lowest address holds MSB
// (RULE13) Mask register byte accessible, zero excludes
// (RULE14) Profiling flag set first entry, cleared end
// (RULE15) Single match pulse when criteria hold
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
`include "dbgca_consts.svh"

module dbgca_match
  import dbgca_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic [`DBGCA_RAW-1:0] reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  session_armed,
  input  wire logic                  profile_start,
  input  wire logic                  profile_end,
  input  wire logic                  bus_valid,
  input  wire logic [`DBGCA_AW-1:0]  bus_addr,
  input  wire logic [`DBGCA_DW-1:0]  bus_data,
  input  wire logic                  bus_rw,
  input  wire logic                  pc_valid,
  input  wire logic [`DBGCA_AW-1:0]  pc_addr,
  output logic                       match,
  output logic                       profiling_active
);

  dbgca_state_t st_q;
  dbgca_state_t st_d;

  logic                 blocked;
  logic                 on;
  logic                 pc_sel;
  logic                 inv;
  logic                 dir_en;
  logic                 dir_val;
  logic                 addr_hit;
  logic                 pc_hit;
  logic                 data_eq;
  logic                 data_ok;
  logic                 dir_ok;
  logic                 hit;
  logic [`DBGCA_RAW-1:0] ofs;

  always_comb begin
    blocked  = session_armed | st_q.prof;                  // RULE1
    on       = st_q.ctl[`DBGCA_ON_BIT];
    pc_sel   = st_q.ctl[`DBGCA_PC_BIT];
    inv      = st_q.ctl[`DBGCA_INV_BIT];
    dir_en   = st_q.ctl[`DBGCA_DIRE_BIT];
    dir_val  = st_q.ctl[`DBGCA_DIR_BIT];
    addr_hit = (bus_addr == st_q.addr);                    // RULE9
    pc_hit   = (pc_addr == st_q.addr);                     // RULE9
    data_eq  = (((bus_data ^ st_q.data) & st_q.mask)
                == `DBGCA_DATA_RST);                       // RULE10 RULE11 RULE13
    data_ok  = inv ? !data_eq : data_eq;                   // RULE2
    dir_ok   = !dir_en || (bus_rw == dir_val);             // RULE4 RULE5 RULE7
    if (pc_sel) begin                                      // RULE3
      hit = pc_valid && pc_hit;                            // RULE8
    end else begin
      hit = bus_valid && addr_hit && data_ok && dir_ok;
    end
  end

  always_comb begin
    st_d       = st_q;
    st_d.match = on && hit;                                // RULE6 RULE15
    st_d.rdata = 8'h00;
    ofs        = reg_addr;
    // Profiling flag, set wins over clear
    if (profile_start) begin
      st_d.prof = 1'b1;                                    // RULE14
    end else if (profile_end) begin
      st_d.prof = 1'b0;                                    // RULE14
    end
    // Register writes
    if (reg_wr && !blocked) begin                          // RULE1
      if (ofs == `DBGCA_CTL_OFS) begin
        st_d.ctl = reg_wdata & `DBGCA_CTL_WMASK;
      end else if (ofs == `DBGCA_ADDR_OFS) begin
        st_d.addr[23:16] = reg_wdata;
      end else if (ofs == `DBGCA_ADDR_OFS + 16'h0001) begin
        st_d.addr[15:8] = reg_wdata;
      end else if (ofs == `DBGCA_ADDR_OFS + 16'h0002) begin
        st_d.addr[7:0] = reg_wdata;
      end else if (ofs == `DBGCA_DATA_OFS) begin
        st_d.data[31:24] = reg_wdata;                      // RULE12
      end else if (ofs == `DBGCA_DATA_OFS + 16'h0001) begin
        st_d.data[23:16] = reg_wdata;                      // RULE12
      end else if (ofs == `DBGCA_DATA_OFS + 16'h0002) begin
        st_d.data[15:8] = reg_wdata;                       // RULE12
      end else if (ofs == `DBGCA_DATA_OFS + 16'h0003) begin
        st_d.data[7:0] = reg_wdata;                        // RULE12
      end else if (ofs == `DBGCA_MASK_OFS) begin
        st_d.mask[31:24] = reg_wdata;                      // RULE13
      end else if (ofs == `DBGCA_MASK_OFS + 16'h0001) begin
        st_d.mask[23:16] = reg_wdata;                      // RULE13
      end else if (ofs == `DBGCA_MASK_OFS + 16'h0002) begin
        st_d.mask[15:8] = reg_wdata;                       // RULE13
      end else if (ofs == `DBGCA_MASK_OFS + 16'h0003) begin
        st_d.mask[7:0] = reg_wdata;                        // RULE13
      end
    end
    // Register reads, allowed at any time
    if (reg_rd) begin
      if (ofs == `DBGCA_CTL_OFS) begin
        st_d.rdata = st_q.ctl;
      end else if (ofs == `DBGCA_STAT_OFS) begin
        st_d.rdata[`DBGCA_ST_PROF]  = st_q.prof;
        st_d.rdata[`DBGCA_ST_BLOCK] = blocked;
        st_d.rdata[`DBGCA_ST_MATCH] = st_q.match;
      end else if (ofs == `DBGCA_ADDR_OFS) begin
        st_d.rdata = st_q.addr[23:16];
      end else if (ofs == `DBGCA_ADDR_OFS + 16'h0001) begin
        st_d.rdata = st_q.addr[15:8];
      end else if (ofs == `DBGCA_ADDR_OFS + 16'h0002) begin
        st_d.rdata = st_q.addr[7:0];
      end else if (ofs == `DBGCA_DATA_OFS) begin
        st_d.rdata = st_q.data[31:24];
      end else if (ofs == `DBGCA_DATA_OFS + 16'h0001) begin
        st_d.rdata = st_q.data[23:16];
      end else if (ofs == `DBGCA_DATA_OFS + 16'h0002) begin
        st_d.rdata = st_q.data[15:8];
      end else if (ofs == `DBGCA_DATA_OFS + 16'h0003) begin
        st_d.rdata = st_q.data[7:0];
      end else if (ofs == `DBGCA_MASK_OFS) begin
        st_d.rdata = st_q.mask[31:24];
      end else if (ofs == `DBGCA_MASK_OFS + 16'h0001) begin
        st_d.rdata = st_q.mask[23:16];
      end else if (ofs == `DBGCA_MASK_OFS + 16'h0002) begin
        st_d.rdata = st_q.mask[15:8];
      end else if (ofs == `DBGCA_MASK_OFS + 16'h0003) begin
        st_d.rdata = st_q.mask[7:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q.ctl   <= `DBGCA_CTL_RST;
      st_q.addr  <= `DBGCA_ADDR_RST;
      st_q.data  <= `DBGCA_DATA_RST;
      st_q.mask  <= `DBGCA_MASK_RST;
      st_q.prof  <= 1'b0;
      st_q.match <= 1'b0;
      st_q.rdata <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata        = st_q.rdata;
  assign match            = st_q.match;
  assign profiling_active = st_q.prof;

  // Checks
  a_write_blocked: // RULE1
    assert property (@(posedge clock) disable iff (!rst_n)
      (reg_wr && (session_armed || st_q.prof)
       && reg_addr == `DBGCA_CTL_OFS)
      |=> $stable(st_q.ctl))
    else $error("Control written while blocked");

  a_invert_data: // RULE2
    assert property (@(posedge clock) disable iff (!rst_n)
      (on && inv && !pc_sel && bus_valid
       && (bus_data & st_q.mask) == (st_q.data & st_q.mask))
      |=> !match)
    else $error("Inverted match on equal data");

  a_pc_match: // RULE3
    assert property (@(posedge clock) disable iff (!rst_n)
      (on && pc_sel && pc_valid && pc_addr == st_q.addr)
      |=> match)
    else $error("PC hit missed");

  a_direction_qual: // RULE7
    assert property (@(posedge clock) disable iff (!rst_n)
      (on && !pc_sel && dir_en && bus_rw != dir_val)
      |=> !match)
    else $error("Match on wrong direction");

  a_comparator_off: // RULE6
    assert property (@(posedge clock) disable iff (!rst_n)
      !on |=> !match)
    else $error("Match while disabled");

  a_masked_match: // RULE11
    assert property (@(posedge clock) disable iff (!rst_n)
      (on && !pc_sel && !inv && !dir_en && bus_valid
       && bus_addr == st_q.addr && st_q.mask == `DBGCA_MASK_RST)
      |=> match)
    else $error("Fully masked data did not match");

  a_data_byte: // RULE12
    assert property (@(posedge clock) disable iff (!rst_n)
      (reg_wr && !session_armed && !st_q.prof
       && reg_addr == `DBGCA_DATA_OFS)
      |=> st_q.data[31:24] == $past(reg_wdata))
    else $error("Data top byte not written");

  a_profile_flag: // RULE14
    assert property (@(posedge clock) disable iff (!rst_n)
      profile_start |=> profiling_active)
    else $error("Profiling flag not set");

  a_read_ctl: // RULE1
    assert property (@(posedge clock) disable iff (!rst_n)
      (reg_rd && reg_addr == `DBGCA_CTL_OFS)
      |=> reg_rdata == $past(st_q.ctl))
    else $error("Control read back wrong");

  a_read_status: // RULE1
    assert property (@(posedge clock) disable iff (!rst_n)
      (reg_rd && reg_addr == `DBGCA_STAT_OFS)
      |=> reg_rdata[`DBGCA_ST_BLOCK] == $past(session_armed || profiling_active))
    else $error("Blocked status read back wrong");

  a_read_mask: // RULE13
    assert property (@(posedge clock) disable iff (!rst_n)
      (reg_rd && reg_addr == `DBGCA_MASK_OFS)
      |=> reg_rdata == $past(st_q.mask[31:24]))
    else $error("Mask top byte read back wrong");

  a_read_idle: // RULE1
    assert property (@(posedge clock) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data not cleared");

  a_block_address: // RULE1
    assert property (@(posedge clock) disable iff (!rst_n)
      (reg_wr && (session_armed || profiling_active)
       && reg_addr >= `DBGCA_ADDR_OFS && reg_addr <= `DBGCA_ADDR_OFS + 16'h0002)
      |=> $stable(st_q.addr))
    else $error("Address written while blocked");

  a_block_data: // RULE1
    assert property (@(posedge clock) disable iff (!rst_n)
      (reg_wr && (session_armed || profiling_active)
       && reg_addr >= `DBGCA_DATA_OFS && reg_addr <= `DBGCA_DATA_OFS + 16'h0003)
      |=> $stable(st_q.data))
    else $error("Data written while blocked");

  a_block_mask: // RULE1
    assert property (@(posedge clock) disable iff (!rst_n)
      (reg_wr && (session_armed || profiling_active)
       && reg_addr >= `DBGCA_MASK_OFS && reg_addr <= `DBGCA_MASK_OFS + 16'h0003)
      |=> $stable(st_q.mask))
    else $error("Mask written while blocked");

  a_data_source: // RULE3
    assert property (@(posedge clock) disable iff (!rst_n)
      (!pc_sel && !bus_valid) |=> !match)
    else $error("Data mode matched without access");

  a_direction_read: // RULE4
    assert property (@(posedge clock) disable iff (!rst_n)
      (on && !pc_sel && !inv && dir_en && bus_valid && bus_rw == dir_val
       && bus_addr == st_q.addr
       && (bus_data & st_q.mask) == (st_q.data & st_q.mask))
      |=> match)
    else $error("Qualified access missed");

  a_direction_free: // RULE5
    assert property (@(posedge clock) disable iff (!rst_n)
      (on && !pc_sel && !inv && !dir_en && bus_valid && bus_addr == st_q.addr
       && (bus_data & st_q.mask) == (st_q.data & st_q.mask))
      |=> match)
    else $error("Unqualified access missed");

  a_pc_no_fetch: // RULE8
    assert property (@(posedge clock) disable iff (!rst_n)
      (pc_sel && !pc_valid) |=> !match)
    else $error("PC mode matched without fetch");

  a_pc_data_blind: // RULE8
    assert property (@(posedge clock) disable iff (!rst_n)
      (on && pc_sel && inv && pc_valid && pc_addr == st_q.addr)
      |=> match)
    else $error("PC hit blocked by data settings");

  a_address_miss: // RULE9
    assert property (@(posedge clock) disable iff (!rst_n)
      (!pc_sel && bus_addr != st_q.addr) |=> !match)
    else $error("Match on wrong data address");

  a_pc_miss: // RULE9
    assert property (@(posedge clock) disable iff (!rst_n)
      (pc_sel && pc_addr != st_q.addr) |=> !match)
    else $error("Match on wrong PC address");

  a_data_miss: // RULE10
    assert property (@(posedge clock) disable iff (!rst_n)
      (!pc_sel && !inv && (bus_data & st_q.mask) != (st_q.data & st_q.mask))
      |=> !match)
    else $error("Match on differing data");

  a_invert_differ: // RULE2
    assert property (@(posedge clock) disable iff (!rst_n)
      (on && !pc_sel && inv && !dir_en && bus_valid && bus_addr == st_q.addr
       && (bus_data & st_q.mask) != (st_q.data & st_q.mask))
      |=> match)
    else $error("Inverted match on differing data missed");

  a_data_low_byte: // RULE12
    assert property (@(posedge clock) disable iff (!rst_n)
      (reg_wr && !session_armed && !profiling_active
       && reg_addr == `DBGCA_DATA_OFS + 16'h0003)
      |=> st_q.data[7:0] == $past(reg_wdata))
    else $error("Data low byte not written");

  a_mask_byte: // RULE13
    assert property (@(posedge clock) disable iff (!rst_n)
      (reg_wr && !session_armed && !profiling_active
       && reg_addr == `DBGCA_MASK_OFS)
      |=> st_q.mask[31:24] == $past(reg_wdata))
    else $error("Mask top byte not written");

  a_profile_clear: // RULE14
    assert property (@(posedge clock) disable iff (!rst_n)
      (profile_end && !profile_start) |=> !profiling_active)
    else $error("Profiling flag not cleared");

  a_profile_hold: // RULE14
    assert property (@(posedge clock) disable iff (!rst_n)
      (!profile_start && !profile_end) |=> $stable(profiling_active))
    else $error("Profiling flag changed without event");

  a_match_idle: // RULE15
    assert property (@(posedge clock) disable iff (!rst_n)
      (!bus_valid && !pc_valid) |=> !match)
    else $error("Match without any access");

endmodule : dbgca_match

// >>> dbgca_core.sv
// Core model: data accesses and PC fetches.
// Assumes one caller at a time, on the shared clock.
`timescale 1ns/100ps
module dbgca_core
  import dbgca_pkg::*;
(
  input  wire logic        clock,
  output logic             bus_valid,
  output logic [23:0]      bus_addr,
  output logic [31:0]      bus_data,
  output logic             bus_rw,
  output logic             pc_valid,
  output logic [23:0]      pc_addr
);
  initial {bus_valid, bus_addr, bus_data, bus_rw, pc_valid, pc_addr} = '0;
  // One access cycle, then scrambled idle buses
  task automatic issue(input logic dv, input logic [23:0] a, input logic [31:0] d,
                       input logic rw, input logic pv);
    @(posedge clock);
    bus_valid <= dv;
    bus_addr  <= a;
    bus_data  <= d;
    bus_rw    <= rw;
    pc_valid  <= pv;
    pc_addr   <= a;
    @(posedge clock);
    bus_valid <= 1'b0;
    pc_valid  <= 1'b0;
    bus_addr  <= ~a;
    bus_data  <= ~d;
    bus_rw    <= ~rw;
    pc_addr   <= ~a;
  endtask : issue
endmodule : dbgca_core

// >>> dbgca_match_tb.sv
// Testbench of debug comparator A with reference model.
// Assumes dbgca_consts.svh on the include path.
`timescale 1ns/100ps
`include "dbgca_consts.svh"
module dbgca_match_tb;
  import dbgca_pkg::*;
  logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic session_armed = 0, profile_start = 0, profile_end = 0;
  logic [15:0] reg_addr = '0;
  logic [7:0]  reg_wdata = '0, reg_rdata, ctl_m = '0;
  logic        bus_valid, bus_rw, pc_valid, match, profiling_active, prof_m = 0;
  logic [23:0] bus_addr, pc_addr, addr_m = '0, a;
  logic [31:0] bus_data, data_m = '0, mask_m = '0, d;
  int          err_count = 0, tests_run = 0;
  always #25 clock = ~clock;
  dbgca_match dbgca_match_i (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .session_armed, .profile_start, .profile_end, .bus_valid, .bus_addr, .bus_data, .bus_rw,
    .pc_valid, .pc_addr, .match, .profiling_active);
  dbgca_core dbgca_core_i (.clock, .bus_valid, .bus_addr, .bus_data, .bus_rw, .pc_valid, .pc_addr);
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic logic [7:0] rmodel(input logic [15:0] r);
    if (r == `DBGCA_CTL_OFS) return ctl_m;
    if (r == `DBGCA_STAT_OFS) return {6'h0, session_armed | prof_m, prof_m};
    if (r >= 16'h115 && r <= 16'h117) return addr_m[8*(16'h117-r) +: 8];
    if (r >= 16'h118 && r <= 16'h11b) return data_m[8*(16'h11b-r) +: 8];
    if (r >= 16'h11c && r <= 16'h11f) return mask_m[8*(16'h11f-r) +: 8];
    return 8'h00;
  endfunction : rmodel
  task automatic wr(input logic [15:0] r, input logic [7:0] v);
    @(posedge clock);
    reg_addr  <= r;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    if (!session_armed && !prof_m) begin
      if (r == `DBGCA_CTL_OFS) ctl_m = v & `DBGCA_CTL_WMASK;
      if (r >= 16'h115 && r <= 16'h117) addr_m[8*(16'h117-r) +: 8] = v;
      if (r >= 16'h118 && r <= 16'h11b) data_m[8*(16'h11b-r) +: 8] = v;
      if (r >= 16'h11c && r <= 16'h11f) mask_m[8*(16'h11f-r) +: 8] = v;
    end
  endtask : wr
  task automatic rd(input logic [15:0] r);
    @(posedge clock);
    reg_addr <= r;
    reg_rd   <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    check("reg_rdata", {24'h0, rmodel(r)}, {24'h0, reg_rdata});
  endtask : rd
  task automatic pulse(input logic s);
    @(posedge clock);
    if (s) profile_start <= 1'b1;
    else profile_end <= 1'b1;
    @(posedge clock);
    profile_start <= 1'b0;
    profile_end   <= 1'b0;
    prof_m = s;
    @(negedge clock);
    check("profiling_active", {31'h0, prof_m}, {31'h0, profiling_active});
  endtask : pulse
  function automatic logic hit_m(input logic dv, input logic rw, input logic pv);
    if (!ctl_m[0]) return 1'b0;
    if (ctl_m[5]) return pv && a == addr_m;
    return dv && a == addr_m && ((((d ^ data_m) & mask_m) != 0) == ctl_m[6])
           && (!ctl_m[2] || rw == ctl_m[3]);
  endfunction : hit_m
  task automatic complete_run;
    $display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    #2000000;
    err_count++;
    complete_run();
  end
  initial begin
    logic dv, rw, pv;
    void'($urandom(32'hc11a));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    for (int r = 16'h110; r < 16'h121; r++) rd(r[15:0]);
    for (int r = 16'h110; r < 16'h120; r++) if (r != 16'h111) wr(r[15:0], 8'($urandom));
    for (int r = 16'h110; r < 16'h121; r++) if (r != 16'h111) rd(r[15:0]);
    $display("Test registers done");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) @(posedge clock) session_armed <= 1'b1;
      else pulse(1'b1);
      wr(16'h118, ~data_m[31:24]);
      wr(16'h115, ~addr_m[23:16]);
      wr(16'h11c, ~mask_m[31:24]);
      wr(`DBGCA_CTL_OFS, ~ctl_m);
      rd(16'h118);
      rd(16'h115);
      rd(16'h11c);
      rd(`DBGCA_CTL_OFS);
      rd(`DBGCA_STAT_OFS);
      if (k == 0) @(posedge clock) session_armed <= 1'b0;
      else pulse(1'b0);
    end
    $display("Test write blocking done");
    for (int n = 0; n < 800; n++) begin
      if (n % 4 == 0) begin
        wr(`DBGCA_CTL_OFS, 8'($urandom) | {7'h0, n % 16 != 4});
        for (int r = 16'h115; r < 16'h120; r++) wr(r[15:0], (r >= 16'h11c && n % 16 == 0) ? 8'h00 : 8'($urandom));
      end
      a = ($urandom % 2) ? addr_m : addr_m ^ (24'h1 << ($urandom % 24));
      d = data_m ^ ($urandom & (($urandom % 2) ? ~mask_m : 32'hffffffff));
      dv = 1'($urandom);
      rw = 1'($urandom);
      pv = 1'($urandom);
      dbgca_core_i.issue(dv, a, d, rw, pv);
      @(negedge clock);
      check("match", {31'h0, hit_m(dv, rw, pv)}, {31'h0, match});
    end
    $display("Test matching done");
    complete_run();
  end
endmodule : dbgca_match_tb
